// ---- core/sic_map.svh ----
// Port addresses, field positions, reset values and timing counts for the interrupt controller.
// Assumes the includer sits on a 200 MHz core clock with an 8-bit I/O port bus.
// What this block does
// - Command at port 90h, mask at 91h
// - Mask bit n masks input n, 1 masks
// - Writing 20h ends current interrupt service
// - Requests sensed by level, pending while high
// - Input 0 maps to type 8, entry 20h
// - Inputs 0..7 fixed sources, types 8..F
// - Delivered request lines are active high
// - Shared bus line is inverted first
// - Floating unmasked input gives spurious interrupt
// - Timer source is a 16-bit counter channel
// - Priority is programmable by software
// - Interrupt path failure lights indicator 4
`ifndef SIC_MAP_SVH
`define SIC_MAP_SVH

// ==========================================================
// Port addresses
`define SIC_CMD_PORT        8'h90
`define SIC_MASK_PORT       8'h91
// Command codes
`define SIC_EOS_CMD         8'h20
`define SIC_PRIO_CMD_BASE   8'hC0
`define SIC_PRIO_CMD_MASK   8'hF8
`define SIC_TIMER_LOAD_LO   8'h40
`define SIC_TIMER_LOAD_HI   8'h41
// Reset values
`define SIC_MASK_RESET      8'hFF
`define SIC_VECTOR_BASE     8'h08
`define SIC_TIMER_RESET     16'hFFFF
// Timer tick: about 2 us per count at 200 MHz
`define SIC_TICK_NS         2000
`define SIC_CLK_NS          5
`define SIC_TICK_CYCLES     (`SIC_TICK_NS / `SIC_CLK_NS)
// Diagnostic indicator position
`define SIC_DIAG_LED        4
// Acknowledge timeout for failure detection
`define SIC_ACK_TIMEOUT     1024

`endif

// ---- core/sic_pkg.sv ----
// Types shared by the interrupt controller.
// Assumes the constants header is included alongside.
package sic_pkg;
	// ==========================================================
	// Delivery state
	typedef enum logic [1:0] {
		SIC_IDLE = 2'b00,
		SIC_RAISE = 2'b01,
		SIC_FAIL = 2'b10
	} sic_state_t;
endpackage

// ---- core/sic_top.sv ----
// Interrupt controller: eight level requests, mask, in-service, vector output.
// Assumes one 200 MHz clock, synchronous reset and an I/O strobe bus from the core.
`timescale 1ns/100ps
`include "sic_map.svh"
module sic_top
	import sic_pkg::*;
#(
	parameter int TICK_CYCLES = `SIC_TICK_CYCLES,
	parameter int ACK_TIMEOUT = `SIC_ACK_TIMEOUT
) (
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic [7:0] io_addr,
	input  wire logic [7:0] io_wdata,
	input  wire logic       io_wr,
	input  wire logic       io_rd,
	output logic      [7:0] io_rdata,
	input  wire logic       keyboard_request,
	input  wire logic       shared_bus_request_n,
	input  wire logic       serial_slot3_request,
	input  wire logic       serial_slot4_request,
	input  wire logic       fixed_disk_request,
	input  wire logic       floppy_request,
	input  wire logic       printer_slot_request,
	input  wire logic       vector_acknowledge,
	output logic            cpu_interrupt,
	output logic      [7:0] vector_type,
	output logic            timer_request,
	output logic      [7:0] diag_leds
);
	// ==========================================================
	// Pin synchronisers
	logic [6:0] pin_meta_reg;  // First stage, read only by second
	logic [6:0] pin_sync_reg;  // Safe samples
	logic [1:0] ack_sync_reg;  // Acknowledge synchroniser
	logic       ack_prev_reg;  // Edge detect on synced ack
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pin_meta_reg <= 7'h00;
			pin_sync_reg <= 7'h00;
			ack_sync_reg <= 2'b00;
			ack_prev_reg <= 1'b0;
		end else begin
			// Shared bus line is active low, inverted here
			pin_meta_reg <= {printer_slot_request, floppy_request, fixed_disk_request,
				serial_slot4_request, serial_slot3_request, ~shared_bus_request_n,
				keyboard_request};
			pin_sync_reg <= pin_meta_reg;
			ack_sync_reg <= {ack_sync_reg[0], vector_acknowledge};
			ack_prev_reg <= ack_sync_reg[1];
		end
	end
	wire logic ack_pulse = ack_sync_reg[1] & ~ack_prev_reg;

	// ==========================================================
	// Timer channel: 16-bit reload counter with about 2 us ticks
	logic [15:0] timer_reload_reg;  // Software period
	logic [15:0] timer_count_reg;   // Running count
	logic [15:0] tick_cnt_reg;      // Prescaler
	wire logic cmd_wr  = io_wr && (io_addr == `SIC_CMD_PORT);
	wire logic mask_wr = io_wr && (io_addr == `SIC_MASK_PORT);
	logic [7:0] timer_lo_reg; // Staged low byte
	logic       timer_stage_reg; // Next data write is a timer byte
	logic       timer_hi_reg;    // Staged byte is high
	always_ff @(posedge core_clk) begin
		if (reset) begin
			tick_cnt_reg <= 16'h0000;
			timer_count_reg <= `SIC_TIMER_RESET;
			timer_request <= 1'b0;
		end else if (tick_cnt_reg == 16'(TICK_CYCLES - 1)) begin
			tick_cnt_reg <= 16'h0000;
			// Square wave: output toggles at each reload, half period 2 us..131 ms
			if (timer_count_reg == 16'h0000) begin
				timer_count_reg <= timer_reload_reg;
				timer_request <= ~timer_request;
			end else begin
				timer_count_reg <= timer_count_reg - 16'h0001;
			end
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 16'h0001;
		end
	end

	// ==========================================================
	// Mask via mask port, priority and timer loads via command port
	logic [7:0] mask_reg;       // 1 masks the input
	logic [2:0] low_prio_reg;   // Input holding lowest priority
	always_ff @(posedge core_clk) begin
		if (reset) begin
			mask_reg <= `SIC_MASK_RESET;
			low_prio_reg <= 3'd7;
			timer_reload_reg <= `SIC_TIMER_RESET;
			timer_lo_reg <= 8'h00;
			timer_stage_reg <= 1'b0;
			timer_hi_reg <= 1'b0;
		end else begin
			if (mask_wr && !timer_stage_reg)
				mask_reg <= io_wdata;
			if (cmd_wr) begin
				// Rotate priority so chosen input becomes lowest
				if ((io_wdata & `SIC_PRIO_CMD_MASK) == `SIC_PRIO_CMD_BASE)
					low_prio_reg <= io_wdata[2:0];
				if (io_wdata == `SIC_TIMER_LOAD_LO || io_wdata == `SIC_TIMER_LOAD_HI) begin
					timer_stage_reg <= 1'b1;
					timer_hi_reg <= io_wdata[0];
				end
			end else if (mask_wr && timer_stage_reg) begin
				// Timer byte borrows the mask port address once
				timer_stage_reg <= 1'b0;
				if (timer_hi_reg)
					timer_reload_reg <= {io_wdata, timer_lo_reg};
				else
					timer_lo_reg <= io_wdata;
			end
		end
	end

	// ==========================================================
	// Priority resolution
	// Rank of an input: 0 is highest, 7 lowest
	function automatic logic [2:0] sic_rank(input logic [2:0] idx, input logic [2:0] low);
		sic_rank = 3'(idx - low - 3'd1);
	endfunction
	// Index of best set bit under current rotation
	function automatic logic [3:0] sic_pick(input logic [7:0] bits, input logic [2:0] low);
		logic [3:0] best;
		best = 4'h8;
		for (int k = 7; k >= 0; k--) begin
			if (bits[3'(k + int'(low) + 1)])
				best = {1'b0, 3'(k + int'(low) + 1)};
		end
		sic_pick = best;
	endfunction

	// Level view: tied-high inputs appear as requests, so unmask only fitted slots
	wire logic [7:0] req_level = {pin_sync_reg, timer_request};
	wire logic [7:0] req_live  = req_level & ~mask_reg;
	logic [7:0] in_service_reg; // Interrupts being handled
	wire logic [3:0] best_req = sic_pick(req_live, low_prio_reg);
	wire logic [3:0] best_isr = sic_pick(in_service_reg, low_prio_reg);
	// Request beats service only at strictly higher priority
	wire logic deliver = !best_req[3] && (best_isr[3] ||
		sic_rank(best_req[2:0], low_prio_reg) < sic_rank(best_isr[2:0], low_prio_reg));

	// ==========================================================
	// Delivery and acknowledge
	sic_state_t state_reg;      // Delivery state
	logic [10:0] wait_cnt_reg;  // Acknowledge timeout counter
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg <= SIC_IDLE;
			cpu_interrupt <= 1'b0;
			vector_type <= `SIC_VECTOR_BASE;
			in_service_reg <= 8'h00;
			wait_cnt_reg <= 11'd0;
			diag_leds <= 8'h00;
		end else begin
			case (state_reg)
				SIC_IDLE: begin
					if (deliver) begin
						state_reg <= SIC_RAISE;
						cpu_interrupt <= 1'b1;
						vector_type <= `SIC_VECTOR_BASE + {5'd0, best_req[2:0]};
						wait_cnt_reg <= 11'd0;
					end
				end
				SIC_RAISE: begin
					if (ack_pulse) begin
						state_reg <= SIC_IDLE;
						cpu_interrupt <= 1'b0;
						in_service_reg[vector_type[2:0]] <= 1'b1;
					end else if (!deliver) begin
						// Level dropped before acknowledge: withdraw
						state_reg <= SIC_IDLE;
						cpu_interrupt <= 1'b0;
					end else if (wait_cnt_reg == 11'(ACK_TIMEOUT)) begin
						state_reg <= SIC_FAIL;
						cpu_interrupt <= 1'b0;
						diag_leds[`SIC_DIAG_LED] <= 1'b1;
					end else begin
						wait_cnt_reg <= wait_cnt_reg + 11'd1;
					end
				end
				SIC_FAIL: begin
					// Indicator stays lit until reset
					state_reg <= SIC_FAIL;
				end
				default: state_reg <= SIC_IDLE;
			endcase
			// End of service clears highest priority in-service bit
			if (cmd_wr && io_wdata == `SIC_EOS_CMD && !best_isr[3] &&
				!(state_reg == SIC_RAISE && ack_pulse && vector_type[2:0] == best_isr[2:0]))
				in_service_reg[best_isr[2:0]] <= 1'b0;
		end
	end

	// ==========================================================
	// Read port
	always_ff @(posedge core_clk) begin
		if (reset)
			io_rdata <= 8'h00;
		else if (io_rd && io_addr == `SIC_MASK_PORT)
			io_rdata <= mask_reg;
		else if (io_rd && io_addr == `SIC_CMD_PORT)
			io_rdata <= in_service_reg;
		else
			io_rdata <= 8'h00;
	end

	// ==========================================================
	// Checks
	mask_reset_a: assert property (@(posedge core_clk) $fell(reset) |-> mask_reg == 8'hFF)
		else $error("mask not all set after reset");
	mask_write_a: assert property (@(posedge core_clk) disable iff (reset)
		mask_wr && !timer_stage_reg |=> mask_reg == $past(io_wdata))
		else $error("mask write lost");
	masked_quiet_a: assert property (@(posedge core_clk) disable iff (reset)
		state_reg == SIC_IDLE && mask_reg == 8'hFF |=> !cpu_interrupt)
		else $error("interrupt raised while all masked");
	vector_range_a: assert property (@(posedge core_clk) disable iff (reset)
		cpu_interrupt |-> vector_type >= 8'h08 && vector_type <= 8'h0F)
		else $error("vector out of range");
	bus_invert_a: assert property (@(posedge core_clk) disable iff (reset)
		shared_bus_request_n [*3] |-> !pin_sync_reg[1])
		else $error("shared bus line not inverted");
	eos_clear_a: assert property (@(posedge core_clk) disable iff (reset)
		cmd_wr && io_wdata == 8'h20 && $onehot(in_service_reg) && !ack_pulse |=> in_service_reg == 8'h00)
		else $error("end of service did not clear");
	level_raise_a: assert property (@(posedge core_clk) disable iff (reset)
		state_reg == SIC_IDLE && in_service_reg == 8'h00 && req_live != 8'h00 |=> cpu_interrupt)
		else $error("pending level not delivered");
	diag_fail_a: assert property (@(posedge core_clk) disable iff (reset)
		state_reg == SIC_FAIL |-> diag_leds[4])
		else $error("failure indicator dark");
endmodule // sic_top

// ---- tb/sic_cpu_model.sv ----
// Processor core model: takes offered vectors.
// Assumes controller outputs change on rising edges.
`timescale 1ns/100ps
module sic_cpu_model
	import sic_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       cpu_interrupt,
	input  wire logic [7:0] vector_type,
	input  wire logic       ack_en,
	input  wire logic [3:0] ack_wait,
	output logic            vector_acknowledge,
	output logic      [7:0] taken_vector
);
	// ==========
	// Acknowledge
	logic [3:0] wait_reg; // Cycles held off before ack
	// Ack stays up until the offer is withdrawn
	always @(negedge core_clk) begin
		if (reset) begin
			vector_acknowledge <= 1'b0;
			taken_vector <= 8'h00;
			wait_reg <= 4'h0;
		end else if (vector_acknowledge) begin
			// Drop only once the controller lets go
			if (cpu_interrupt !== 1'b1) begin
				vector_acknowledge <= 1'b0;
			end
		end else if (cpu_interrupt === 1'b1 && ack_en) begin
			// Slow answers let the offer stand longer
			if (wait_reg >= ack_wait) begin
				vector_acknowledge <= 1'b1;
				taken_vector <= vector_type;
				wait_reg <= 4'h0;
			end else begin
				wait_reg <= wait_reg + 4'h1;
			end
		end else begin
			wait_reg <= 4'h0;
		end
	end
endmodule // sic_cpu_model

// ---- tb/system_interrupt_controller_tb_top.sv ----
// Bench for the interrupt controller.
// Assumes TICK_CYCLES 1 and ACK_TIMEOUT 16, so the reset count of the timer ends inside the run.
`timescale 1ns/100ps
module system_interrupt_controller_tb_top
	import sic_pkg::*;
();
	// ==========
	// Signals
	logic       core_clk = 0;
	logic       reset = 1;
	logic [7:0] io_addr = 0, io_wdata = 0, io_rdata, vector_type, diag_leds, taken_vector;
	logic       io_wr = 0, io_rd = 0, cpu_interrupt, timer_request, vector_acknowledge;
	logic [7:1] req = 0;  // Requests, index is input number
	logic       ack_en = 1;
	logic [3:0] ack_wait = 0;
	int         n_fail = 0, n_compared = 0, cycles = 0;
	always #2.5 core_clk = ~core_clk;
	sic_top #(.TICK_CYCLES(1), .ACK_TIMEOUT(16)) u_sic_top (.core_clk(core_clk), .reset(reset),
		.io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
		.keyboard_request(req[1]), .shared_bus_request_n(~req[2]), .serial_slot3_request(req[3]),
		.serial_slot4_request(req[4]), .fixed_disk_request(req[5]), .floppy_request(req[6]),
		.printer_slot_request(req[7]), .vector_acknowledge(vector_acknowledge),
		.cpu_interrupt(cpu_interrupt), .vector_type(vector_type), .timer_request(timer_request),
		.diag_leds(diag_leds));
	sic_cpu_model u_sic_cpu_model (.core_clk(core_clk), .reset(reset), .cpu_interrupt(cpu_interrupt),
		.vector_type(vector_type), .ack_en(ack_en), .ack_wait(ack_wait),
		.vector_acknowledge(vector_acknowledge), .taken_vector(taken_vector));
	// ==========
	// Helpers
	task end_sim;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Hang guard: the timer's first reload alone takes about 65536 cycles
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			n_fail++;
			end_sim;
		end
	end
	task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Idle edge after each strobe so no step drives it twice
	task wr(input logic [7:0] a, input logic [7:0] d);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(negedge core_clk);
		io_wr = 1'b0;
		@(negedge core_clk);
	endtask
	// Read data stands just after the taking edge, checked at the next falling edge
	task rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge core_clk);
		io_rd = 1'b0;
		check(nm, io_rdata, exp);
		@(negedge core_clk);
	endtask
	task wait_vec(input logic [7:0] exp);
		int k;
		for (k = 0; k < 60 && vector_acknowledge !== 1'b1; k++) @(negedge core_clk);
		check("ack", {7'h0, vector_acknowledge}, 8'h01);
		check("vector", taken_vector, exp);
		for (k = 0; k < 60 && vector_acknowledge !== 1'b0; k++) @(negedge core_clk);
		repeat (4) @(negedge core_clk);
	endtask
	task rst;
		reset = 1'b1;
		repeat (6) @(negedge core_clk);
		reset = 1'b0;
	endtask
	// ==========
	// Scenarios
	task t_regs;
		rchk("mask reset", 8'h91, 8'hFF);
		check("diag reset", diag_leds, 8'h00);
		rchk("unmapped", 8'h92, 8'h00);
		wr(8'h91, 8'h5A);
		rchk("mask", 8'h91, 8'h5A);
		wr(8'h91, 8'hFF);
		req[1] = 1'b1;
		repeat (20) @(negedge core_clk);
		check("masked", {7'h0, cpu_interrupt}, 8'h00);
		req[1] = 1'b0;
		repeat (6) @(negedge core_clk);
	endtask
	// Inputs 1..7 alone, level held across one end of service
	task t_sources;
		for (int i = 1; i < 8; i++) begin
			wr(8'h91, ~(8'h01 << i));
			req[i] = 1'b1;
			wait_vec(8'h08 + 8'(i));
			rchk("in service", 8'h90, 8'h01 << i);
			wr(8'h90, 8'h20);
			wait_vec(8'h08 + 8'(i));
			req[i] = 1'b0;
			repeat (6) @(negedge core_clk);
			wr(8'h90, 8'h20);
			rchk("cleared", 8'h90, 8'h00);
			wr(8'h91, 8'hFF);
		end
	endtask
	// Input 3 made lowest, slow acknowledges
	task t_priority;
		ack_wait = 4'h4;
		wr(8'h90, 8'hC3);
		wr(8'h91, 8'h77);
		req[3] = 1'b1;
		req[7] = 1'b1;
		wait_vec(8'h0F);
		rchk("in service", 8'h90, 8'h80);
		req[7] = 1'b0;
		repeat (6) @(negedge core_clk);
		wr(8'h90, 8'h20);
		wait_vec(8'h0B);
		req[3] = 1'b0;
		repeat (6) @(negedge core_clk);
		wr(8'h90, 8'h20);
		wr(8'h91, 8'hFF);
		ack_wait = 4'h0;
	endtask
	// Reload 0010h: each half period is 16 + 1 ticks of one cycle
	task t_timer;
		int n;
		wr(8'h90, 8'h40);
		wr(8'h91, 8'h10);
		wr(8'h90, 8'h41);
		wr(8'h91, 8'h00);
		wr(8'h91, 8'hFE);
		// New period only takes hold once the reset count runs out
		for (n = 0; n < 70000 && cpu_interrupt !== 1'b1; n++) @(negedge core_clk);
		check("timer level", {7'h0, timer_request}, 8'h01);
		wait_vec(8'h08);
		for (n = 0; n < 40 && timer_request !== 1'b0; n++) @(negedge core_clk);
		for (n = 0; n < 40 && timer_request !== 1'b1; n++) @(negedge core_clk);
		check("timer half period", 8'(n), 8'h11);
		wr(8'h91, 8'hFF);
		wr(8'h90, 8'h20);
	endtask
	// No acknowledge: indicator 4 lights, reset clears it
	task t_fail;
		ack_en = 1'b0;
		wr(8'h91, 8'hFD);
		req[1] = 1'b1;
		for (int k = 0; k < 80 && diag_leds[4] !== 1'b1; k++) @(negedge core_clk);
		check("diag", diag_leds, 8'h10);
		req[1] = 1'b0;
		ack_en = 1'b1;
		rst;
		check("diag cleared", diag_leds, 8'h00);
		rchk("mask reset", 8'h91, 8'hFF);
	endtask
	initial begin
		rst;
		t_regs;
		t_sources;
		t_priority;
		t_timer;
		t_fail;
		end_sim;
	end
endmodule // system_interrupt_controller_tb_top
